// file: shared/bst_pkg.sv
// Constants, codes and state types of the boundary scan test port.
`default_nettype none
package bst_pkg;
	localparam int PIN_COUNT     = 8;
	localparam int CELLS_PER_PIN = 3;
	localparam int CELL_OUT      = 0;
	localparam int CELL_OE       = 1;
	localparam int CELL_IN       = 2;
	localparam int CHAIN_LEN     = PIN_COUNT * CELLS_PER_PIN;
	localparam int IR_LEN        = 4;
	localparam int ID_LEN        = 32;

	localparam logic [IR_LEN-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_LEN-1:0] IR_CLAMP   = 4'h2;
	localparam logic [IR_LEN-1:0] IR_HIGHZ   = 4'h3;
	localparam logic [IR_LEN-1:0] IR_SAMPLE  = 4'h4;
	localparam logic [IR_LEN-1:0] IR_IDCODE  = 4'hE;
	localparam logic [IR_LEN-1:0] IR_BYPASS  = 4'hF;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR, ST_PADR, ST_EX2DR,
		ST_UPDR, ST_SELIR, ST_CAPIR, ST_SHIR, ST_EX1IR, ST_PAIR, ST_EX2IR, ST_UPIR
	} bst_state_t;

	typedef enum logic [1:0] {
		MODE_NORMAL, MODE_LATCH, MODE_HIGHZ
	} bst_mode_t;
endpackage
`default_nettype wire

// file: rtl/bst_tap_fsm.sv
// Test port controller state machine.
`timescale 1ns/100ps
`default_nettype none
module bst_tap_fsm (
	// Test port.
	input  wire logic          tck,
	input  wire logic          trst_n,
	input  wire logic          tms,
	// Controller state.
	output var  bst_pkg::bst_state_t state
);
	import bst_pkg::*;

	bst_state_t state_reg;
	bst_state_t state_next;

	assign state = state_reg;

	always_comb begin
		unique case (state_reg)
			ST_TLR:   state_next = tms ? ST_TLR : ST_RTI;
			ST_RTI:   state_next = tms ? ST_SELDR : ST_RTI;
			ST_SELDR: state_next = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: state_next = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  state_next = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: state_next = tms ? ST_UPDR : ST_PADR;
			ST_PADR:  state_next = tms ? ST_EX2DR : ST_PADR;
			ST_EX2DR: state_next = tms ? ST_UPDR : ST_SHDR;
			ST_UPDR:  state_next = tms ? ST_SELDR : ST_RTI;
			ST_SELIR: state_next = tms ? ST_TLR : ST_CAPIR;
			ST_CAPIR: state_next = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  state_next = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: state_next = tms ? ST_UPIR : ST_PAIR;
			ST_PAIR:  state_next = tms ? ST_EX2IR : ST_PAIR;
			ST_EX2IR: state_next = tms ? ST_UPIR : ST_SHIR;
			ST_UPIR:  state_next = tms ? ST_SELDR : ST_RTI;
		endcase
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			state_reg <= ST_TLR;
		end else begin
			state_reg <= state_next;
		end
	end

	chk_five_ones: assert property (
		@(posedge tck) disable iff (!trst_n)
		tms [*5] |=> state_reg == ST_TLR)
		else $error("Five mode select ones did not reach reset state.");

	chk_shift_stay: assert property (
		@(posedge tck) disable iff (!trst_n)
		(state_reg == ST_SHDR && !tms) |=> state_reg == ST_SHDR ##1 state_reg != ST_TLR)
		else $error("Shift-DR left with mode select low.");
endmodule
`default_nettype wire

// file: rtl/bst_top.sv
// Boundary scan test port with instruction, bypass, identity and boundary registers.
`timescale 1ns/100ps
`default_nettype none
module bst_top #(
	// Arbitrary identity value.
	parameter logic [bst_pkg::ID_LEN-1:0] ID_VALUE = 32'h0A5A_5001
) (
	// System side.
	input  wire logic                          REF_CLK,
	input  wire logic                          RST_N,
	// Test port.
	input  wire logic                          TEST_CLOCK_IN,
	input  wire logic                          TEST_RESET_N,
	input  wire logic                          TEST_MODE_SELECT,
	input  wire logic                          TEST_DATA_IN,
	output var  logic                          TEST_DATA_OUT,
	output var  logic                          TEST_DATA_OUT_EN,
	// Pads.
	input  wire logic [bst_pkg::PIN_COUNT-1:0] PAD_IN,
	output var  logic [bst_pkg::PIN_COUNT-1:0] PAD_OUT,
	output var  logic [bst_pkg::PIN_COUNT-1:0] PAD_OE,
	// Core.
	input  wire logic [bst_pkg::PIN_COUNT-1:0] CORE_OUT,
	input  wire logic [bst_pkg::PIN_COUNT-1:0] CORE_OE,
	output var  logic [bst_pkg::PIN_COUNT-1:0] CORE_IN
);
	import bst_pkg::*;

	function automatic logic is_bsr(input logic [IR_LEN-1:0] ir);
		is_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
	endfunction

	function automatic logic is_id(input logic [IR_LEN-1:0] ir);
		is_id = (ir == IR_IDCODE);
	endfunction

	function automatic bst_mode_t mode_of(input logic [IR_LEN-1:0] ir);
		if (ir == IR_EXTEST || ir == IR_CLAMP)
			mode_of = MODE_LATCH;
		else if (ir == IR_HIGHZ)
			mode_of = MODE_HIGHZ;
		else
			mode_of = MODE_NORMAL;
	endfunction

	bst_state_t           state;
	logic [CHAIN_LEN-1:0] cap_raw;
	logic [CHAIN_LEN-1:0] cap_s1_reg,   cap_s1_next;
	logic [CHAIN_LEN-1:0] cap_s2_reg,   cap_s2_next;
	logic [CHAIN_LEN-1:0] cap_s3_reg,   cap_s3_next;
	logic [CHAIN_LEN-1:0] cap_filt_reg, cap_filt_next;
	logic [IR_LEN-1:0]    ir_sh_reg,    ir_sh_next;
	logic [IR_LEN-1:0]    ir_reg,       ir_next;
	logic                 byp_reg,      byp_next;
	logic [ID_LEN-1:0]    id_sh_reg,    id_sh_next;
	logic [CHAIN_LEN-1:0] bsr_sh_reg,   bsr_sh_next;
	logic [PIN_COUNT-1:0] lat_out_reg,  lat_out_next;
	logic [PIN_COUNT-1:0] lat_oe_reg,   lat_oe_next;
	bst_mode_t            mode_reg,     mode_next;
	logic                 tgl_reg,      tgl_next;
	logic                 tdo_reg,      tdo_next;
	logic                 tdo_en_reg,   tdo_en_next;
	logic [PIN_COUNT-1:0] pin_s1_reg,   pin_s1_next;
	logic [PIN_COUNT-1:0] pin_s2_reg,   pin_s2_next;
	logic [PIN_COUNT-1:0] pin_s3_reg,   pin_s3_next;
	logic [PIN_COUNT-1:0] pin_filt_reg, pin_filt_next;
	logic [2:0]           tgl_sync_reg, tgl_sync_next;
	logic                 tgl_seen_reg, tgl_seen_next;
	logic [2:0]           rst_sync_reg, rst_sync_next;
	logic                 rst_filt_reg, rst_filt_next;
	logic [PIN_COUNT-1:0] lo_sys_reg,   lo_sys_next;
	logic [PIN_COUNT-1:0] le_sys_reg,   le_sys_next;
	bst_mode_t            mode_sys_reg, mode_sys_next;
	logic [PIN_COUNT-1:0] pad_out_reg,  pad_out_next;
	logic [PIN_COUNT-1:0] pad_oe_reg,   pad_oe_next;
	logic                 tgl_new;

	bst_tap_fsm u_fsm (
		.tck    (TEST_CLOCK_IN),
		.trst_n (TEST_RESET_N),
		.tms    (TEST_MODE_SELECT),
		.state  (state)
	);

	// Cells per pin: output, enable, input from low to high; test port pins are not pads.
	for (genvar k = 0; k < PIN_COUNT; k++) begin : g_cell
		assign cap_raw[k*CELLS_PER_PIN+CELL_IN]  = PAD_IN[k];
		assign cap_raw[k*CELLS_PER_PIN+CELL_OE]  = CORE_OE[k];
		assign cap_raw[k*CELLS_PER_PIN+CELL_OUT] = CORE_OUT[k];
	end

	// Test clock domain.
	always_comb begin
		cap_s1_next   = cap_raw;
		cap_s2_next   = cap_s1_reg;
		cap_s3_next   = cap_s2_reg;
		cap_filt_next = (cap_s2_reg & cap_s3_reg) | (cap_filt_reg & (cap_s2_reg ^ cap_s3_reg));
		ir_sh_next    = ir_sh_reg;
		ir_next       = ir_reg;
		byp_next      = byp_reg;
		id_sh_next    = id_sh_reg;
		bsr_sh_next   = bsr_sh_reg;
		lat_out_next  = lat_out_reg;
		lat_oe_next   = lat_oe_reg;
		case (state)
			ST_TLR: ir_next = IR_IDCODE;
			ST_CAPIR: ir_sh_next = IR_CAPTURE;
			ST_SHIR: ir_sh_next = {TEST_DATA_IN, ir_sh_reg[IR_LEN-1:1]};
			ST_UPIR: ir_next = ir_sh_reg;
			ST_CAPDR: begin
				byp_next = 1'b0;
				if (is_id(ir_reg))
					id_sh_next = ID_VALUE;
				if (is_bsr(ir_reg))
					bsr_sh_next = cap_filt_reg;
			end
			ST_SHDR: begin
				if (is_id(ir_reg))
					id_sh_next = {TEST_DATA_IN, id_sh_reg[ID_LEN-1:1]};
				else if (is_bsr(ir_reg))
					bsr_sh_next = {TEST_DATA_IN, bsr_sh_reg[CHAIN_LEN-1:1]};
				else
					byp_next = TEST_DATA_IN;
			end
			ST_UPDR: begin
				if (is_bsr(ir_reg)) begin
					for (int k = 0; k < PIN_COUNT; k++) begin
						lat_out_next[k] = bsr_sh_reg[k*CELLS_PER_PIN+CELL_OUT];
						lat_oe_next[k]  = bsr_sh_reg[k*CELLS_PER_PIN+CELL_OE];
					end
				end
			end
			default: begin
			end
		endcase
		mode_next = mode_of(ir_next);
		tgl_next  = tgl_reg ^ ((state == ST_UPDR) || (mode_next != mode_reg));
	end

	always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
		if (!TEST_RESET_N) begin
			cap_s1_reg   <= '0;
			cap_s2_reg   <= '0;
			cap_s3_reg   <= '0;
			cap_filt_reg <= '0;
			ir_sh_reg    <= IR_CAPTURE;
			ir_reg       <= IR_IDCODE;
			byp_reg      <= 1'b0;
			id_sh_reg    <= ID_VALUE;
			bsr_sh_reg   <= '0;
			lat_out_reg  <= '0;
			lat_oe_reg   <= '0;
			mode_reg     <= MODE_NORMAL;
			tgl_reg      <= 1'b0;
		end else begin
			cap_s1_reg   <= cap_s1_next;
			cap_s2_reg   <= cap_s2_next;
			cap_s3_reg   <= cap_s3_next;
			cap_filt_reg <= cap_filt_next;
			ir_sh_reg    <= ir_sh_next;
			ir_reg       <= ir_next;
			byp_reg      <= byp_next;
			id_sh_reg    <= id_sh_next;
			bsr_sh_reg   <= bsr_sh_next;
			lat_out_reg  <= lat_out_next;
			lat_oe_reg   <= lat_oe_next;
			mode_reg     <= mode_next;
			tgl_reg      <= tgl_next;
		end
	end

	// Data out changes on the falling test clock edge.
	always_comb begin
		if (state == ST_SHIR)
			tdo_next = ir_sh_reg[0];
		else if (is_id(ir_reg))
			tdo_next = id_sh_reg[0];
		else if (is_bsr(ir_reg))
			tdo_next = bsr_sh_reg[0];
		else
			tdo_next = byp_reg;
		tdo_en_next = (state == ST_SHIR) || (state == ST_SHDR);
	end

	always_ff @(negedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
		if (!TEST_RESET_N) begin
			tdo_reg    <= 1'b0;
			tdo_en_reg <= 1'b0;
		end else begin
			tdo_reg    <= tdo_next;
			tdo_en_reg <= tdo_en_next;
		end
	end

	// System clock domain.
	always_comb begin
		pin_s1_next   = PAD_IN;
		pin_s2_next   = pin_s1_reg;
		pin_s3_next   = pin_s2_reg;
		pin_filt_next = (pin_s2_reg & pin_s3_reg) | (pin_filt_reg & (pin_s2_reg ^ pin_s3_reg));
		tgl_sync_next = {tgl_sync_reg[1:0], tgl_reg};
		rst_sync_next = {rst_sync_reg[1:0], TEST_RESET_N};
		rst_filt_next = (rst_sync_reg[1] == rst_sync_reg[2]) ? rst_sync_reg[2] : rst_filt_reg;
		tgl_new       = (tgl_sync_reg[1] == tgl_sync_reg[2]) && (tgl_sync_reg[2] != tgl_seen_reg);
		tgl_seen_next = tgl_seen_reg;
		lo_sys_next   = lo_sys_reg;
		le_sys_next   = le_sys_reg;
		mode_sys_next = mode_sys_reg;
		if (tgl_new) begin
			tgl_seen_next = tgl_sync_reg[2];
			lo_sys_next   = lat_out_reg;
			le_sys_next   = lat_oe_reg;
			mode_sys_next = mode_reg;
		end
		if (!rst_filt_reg)
			mode_sys_next = MODE_NORMAL;
		unique case (mode_sys_reg)
			MODE_LATCH: begin
				pad_out_next = lo_sys_reg;
				pad_oe_next  = le_sys_reg;
			end
			MODE_HIGHZ: begin
				pad_out_next = CORE_OUT;
				pad_oe_next  = '0;
			end
			default: begin
				pad_out_next = CORE_OUT;
				pad_oe_next  = CORE_OE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1_reg   <= '0;
			pin_s2_reg   <= '0;
			pin_s3_reg   <= '0;
			pin_filt_reg <= '0;
			tgl_sync_reg <= '0;
			tgl_seen_reg <= 1'b0;
			rst_sync_reg <= '0;
			rst_filt_reg <= 1'b0;
			lo_sys_reg   <= '0;
			le_sys_reg   <= '0;
			mode_sys_reg <= MODE_NORMAL;
			pad_out_reg  <= '0;
			pad_oe_reg   <= '0;
		end else begin
			pin_s1_reg   <= pin_s1_next;
			pin_s2_reg   <= pin_s2_next;
			pin_s3_reg   <= pin_s3_next;
			pin_filt_reg <= pin_filt_next;
			tgl_sync_reg <= tgl_sync_next;
			tgl_seen_reg <= tgl_seen_next;
			rst_sync_reg <= rst_sync_next;
			rst_filt_reg <= rst_filt_next;
			lo_sys_reg   <= lo_sys_next;
			le_sys_reg   <= le_sys_next;
			mode_sys_reg <= mode_sys_next;
			pad_out_reg  <= pad_out_next;
			pad_oe_reg   <= pad_oe_next;
		end
	end

	assign TEST_DATA_OUT    = tdo_reg;
	assign TEST_DATA_OUT_EN = tdo_en_reg;
	assign PAD_OUT          = pad_out_reg;
	assign PAD_OE           = pad_oe_reg;
	assign CORE_IN          = pin_filt_reg;

	chk_tlr_idcode: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		state == ST_TLR |=> ir_reg == IR_IDCODE)
		else $error("Instruction is not IDCODE after reset state.");

	chk_bypass_path: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		(state == ST_SHDR && !is_bsr(ir_reg) && !is_id(ir_reg)) |=> byp_reg == $past(TEST_DATA_IN))
		else $error("Bypass register did not take data in.");

	chk_bypass_zero: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		state == ST_CAPDR |=> !byp_reg)
		else $error("Bypass register did not capture zero.");

	chk_id_capture: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		(state == ST_CAPDR && is_id(ir_reg)) |=> id_sh_reg == ID_VALUE)
		else $error("Identity value not captured.");

	chk_id_shift: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		(state == ST_SHDR && is_id(ir_reg)) |=> id_sh_reg[ID_LEN-1] == $past(TEST_DATA_IN))
		else $error("Identity shift not low bit first.");

	chk_chain_hold: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		(ir_reg == IR_CLAMP || ir_reg == IR_HIGHZ) |=> $stable(bsr_sh_reg))
		else $error("Boundary chain moved under clamp or float.");

	chk_update_latch: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		(state == ST_UPDR && is_bsr(ir_reg)) |=> lat_oe_reg[0] == $past(bsr_sh_reg[CELL_OE]))
		else $error("Update did not load the output latch.");

	chk_tdo_shift: assert property (
		@(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
		TEST_DATA_OUT_EN == (state == ST_SHDR || state == ST_SHIR))
		else $error("Data out enable does not match the shift states.");

	chk_highz_pads: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		mode_sys_reg == MODE_HIGHZ |=> PAD_OE == '0)
		else $error("Pads driven under float instruction.");

	chk_latch_drive: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		mode_sys_reg == MODE_LATCH |=> PAD_OUT == $past(lo_sys_reg))
		else $error("Pads not driven from output latch.");
endmodule
`default_nettype wire

// file: testbench/bst_tester.sv
// Board tester model that drives the test port.
`timescale 1ns/100ps
`default_nettype none
module bst_tester (
	// Test port.
	output var  logic tck,
	output var  logic trst_n,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo,
	input  wire logic tdo_en
);
	logic en_all;
	logic en_q;
	initial begin
		tck = 1'b0;
		trst_n = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		en_all = 1'b1;
	end
	// One test clock; the clock stands still low between frames.
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		q = tdo;
		en_q = tdo_en;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask
	task automatic port_reset();
		logic q;
		trst_n = 1'b0;
		repeat (20) tick(1'b1, 1'b1, q);
		trst_n = 1'b1;
		tick(1'b0, 1'b1, q);
		tms = 1'b1;
	endtask
	task automatic tms_reset();
		logic q;
		repeat (5) tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tms = 1'b1;
	endtask
	task automatic idle(input int n);
		logic q;
		repeat (n) tick(1'b0, 1'b1, q);
		tms = 1'b1;
	endtask
	// Shifts n bits from Run-Test/Idle and returns there.
	task automatic scan(input logic ir, input logic [63:0] din, input int n,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b1, q);
		if (ir)
			tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tick(1'b0, 1'b1, q);
		en_all = 1'b1;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			en_all = en_all & en_q;
			dout[i] = q;
		end
		tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tms = 1'b1;
	endtask
endmodule
`default_nettype wire

// file: testbench/boundary_scan_tap_test.sv
// Self-checking bench for the boundary scan test port.
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_tap_test;
	import bst_pkg::*;
	// Arbitrary identity value, low bit set.
	localparam logic [ID_LEN-1:0] ID_ARB = 32'h5C3A_9E21;
	logic                 ref_clk, rst_n, tck, trst_n, tms, tdi, tdo, tdo_en;
	logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
	logic [63:0]          dout;
	int                   n_mismatch;
	int                   cmp_count;

	bst_top #(.ID_VALUE(ID_ARB)) bst_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
		.TEST_CLOCK_IN(tck), .TEST_RESET_N(trst_n), .TEST_MODE_SELECT(tms),
		.TEST_DATA_IN(tdi), .TEST_DATA_OUT(tdo), .TEST_DATA_OUT_EN(tdo_en),
		.PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .CORE_OUT(core_out),
		.CORE_OE(core_oe), .CORE_IN(core_in));
	bst_tester bst_tester_inst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_en(tdo_en));

	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD %0t %s", $time, msg);
			n_mismatch++;
		end
	endtask
	task automatic wait_pads(input logic [7:0] o, input logic [7:0] e);
		int k;
		k = 0;
		while ((pad_out !== o || pad_oe !== e) && k < 20) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		cmp_count++;
		if (pad_out !== o || pad_oe !== e) begin
			$display("BAD %0t pads not at expected values", $time);
			n_mismatch++;
			summarize();
		end
	endtask
	// Data scan, then checks the output enable seen during and after it.
	task automatic sc(input logic [63:0] din, input int n);
		bst_tester_inst.scan(1'b0, din, n, dout);
		chk({62'h0, bst_tester_inst.en_all, tdo_en}, 64'h2, "data out enable");
	endtask
	task automatic ld(input logic [IR_LEN-1:0] code);
		bst_tester_inst.scan(1'b1, {60'h0, code}, IR_LEN, dout);
		chk(dout, 64'h1, "instruction capture");
	endtask
	function automatic logic [63:0] chain(input logic [7:0] o, input logic [7:0] e,
		input logic [7:0] i);
		chain = '0;
		for (int k = 0; k < PIN_COUNT; k++) begin
			chain[3*k+CELL_OUT] = o[k];
			chain[3*k+CELL_OE] = e[k];
			chain[3*k+CELL_IN] = i[k];
		end
	endfunction
	task automatic id_read();
		sc(64'h0, 32);
		chk(dout, {32'h0, ID_ARB}, "identity after reset");
	endtask

	task automatic t_idcode();
		sc(64'h0000_0000_0000_00C3, 40);
		chk(dout, {24'h00_0000, 8'hC3, ID_ARB}, "identity and surplus bits");
		sc(64'hFFFF_FFFF_FFFF_FFFF, 32);
		chk(dout, {32'h0, ID_ARB}, "identity rewritten");
	endtask
	task automatic t_bypass();
		logic [3:0] codes [4];
		codes = '{IR_BYPASS, 4'h5, 4'h9, 4'hD};
		foreach (codes[j]) begin
			ld(codes[j]);
			sc(64'h0000_0000_0000_0136, 9);
			chk(dout, 64'h0000_0000_0000_006C, "bypass path");
			chk({48'h0, pad_oe, pad_out}, {48'h0, core_oe, core_out}, "bypass pads");
		end
	endtask
	task automatic t_sample();
		ld(IR_SAMPLE);
		sc(chain(8'hA5, 8'h09, 8'h00), 24);
		chk(dout, chain(8'h3C, 8'hF0, 8'h96), "sample snapshot");
		repeat (10) @(posedge ref_clk);
		chk({48'h0, pad_oe, pad_out}, {48'h0, core_oe, core_out}, "preload pads");
		chk({56'h0, core_in}, 64'h96, "core input");
	endtask
	task automatic t_extest();
		ld(IR_EXTEST);
		wait_pads(8'hA5, 8'h09);
		@(posedge ref_clk);
		pad_in <= 8'h69;
		bst_tester_inst.idle(6);
		sc(chain(8'h5A, 8'hF0, 8'h00), 24);
		chk(dout & chain(8'h0, 8'h0, 8'hFF), chain(8'h0, 8'h0, 8'h69), "pin capture");
		wait_pads(8'h5A, 8'hF0);
	endtask
	task automatic t_clamp_highz();
		ld(IR_CLAMP);
		sc(64'h5, 3);
		chk(dout, 64'h2, "clamp bypass");
		repeat (10) @(posedge ref_clk);
		chk({48'h0, pad_oe, pad_out}, 64'hF05A, "clamp pads");
		ld(IR_HIGHZ);
		wait_pads(8'h3C, 8'h00);
		sc(64'h5, 3);
		chk(dout, 64'h2, "highz bypass");
		ld(IR_EXTEST);
		wait_pads(8'h5A, 8'hF0);
	endtask
	task automatic t_resets();
		bst_tester_inst.tms_reset();
		wait_pads(8'h3C, 8'hF0);
		id_read();
		ld(IR_EXTEST);
		wait_pads(8'h5A, 8'hF0);
		bst_tester_inst.port_reset();
		wait_pads(8'h3C, 8'hF0);
		id_read();
	endtask

	initial begin
		rst_n = 1'b0;
		pad_in = '0;
		core_out = '0;
		core_oe = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		bst_tester_inst.port_reset();
		@(posedge ref_clk);
		core_out <= 8'h3C;
		core_oe <= 8'hF0;
		pad_in <= 8'h96;
		wait_pads(8'h3C, 8'hF0);
		t_idcode();
		t_bypass();
		t_sample();
		t_extest();
		t_clamp_highz();
		t_resets();
		summarize();
	end
endmodule
`default_nettype wire
